// File: rtl/cil_pkg.sv
package cil_pkg;
	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned CLK_PERIOD_NS = 50;
	// base time unit in crystal periods; the system clock is the crystal
	localparam int unsigned BASE_UNIT_PERIODS = 40960;
	localparam int unsigned SILENT_UNITS      = 8;
	// serial clock half period, a least time so it rounds up
	localparam int unsigned SK_HALF_NS = 2000;
	localparam logic [7:0]  SK_HALF_CLKS =
		8'((SK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0]  STRAP_SETTLE_CLKS = 4'h8;
	// read frame: start bit, two opcode bits, address, dummy, 16 data
	localparam int unsigned ADDR_BITS = 6;
	localparam logic [2:0]  READ_CMD  = 3'h6;
	localparam logic [4:0]  OUT_BITS  = 5'(3 + ADDR_BITS);
	localparam logic [4:0]  LAST_BIT  = 5'(3 + ADDR_BITS + 17 - 1);
	// word map
	localparam logic [3:0]  W_MARKER = 4'h0;
	localparam logic [3:0]  W_IDENT  = 4'h1;
	localparam logic [3:0]  W_GLOBAL = 4'h2;
	localparam logic [3:0]  W_EDGE   = 4'h3;
	localparam logic [3:0]  W_OUTPUT = 4'h4;
	localparam logic [3:0]  W_DIR    = 4'h5;
	localparam logic [3:0]  W_ANALOG = 4'h6;
	localparam logic [3:0]  W_CTRL   = 4'h7;
	localparam logic [3:0]  W_CONFIG = 4'h8;
	localparam logic [7:0]  EEPROM_VALID_MARKER = 8'hAA;
	localparam logic [7:0]  MIXED_MODE_MARKER   = 8'h55;
	// strap mode constants
	localparam logic [5:0]  STRAP_IDENT_HIGH = 6'h20;
	localparam logic [7:0]  STRAP_PRESCALER  = 8'h03;
	localparam logic [7:0]  OUTPUT_DEFAULT   = 8'hFF;
	localparam logic [7:0]  REG_DEFAULT      = 8'h00;
	// bit timing
	localparam int unsigned FAST_RATE_HZ  = 1_000_000;
	localparam logic [8:0]  FAST_PSC_LIMIT =
		9'(CLK_HZ / (10 * FAST_RATE_HZ));
	localparam logic [6:0]  SAMPLE_PCT_SLOW = 7'h3C;
	localparam logic [6:0]  SAMPLE_PCT_FAST = 7'h50;
	localparam logic [2:0]  SJW_SLOW        = 3'h4;
	localparam logic [2:0]  SJW_FAST        = 3'h2;
	localparam logic [4:0]  MARKER_PORT_LOW = 5'h00;
	localparam logic [1:0]  BUS_MODE_LAST   = 2'h2;

	typedef enum logic [2:0] {
		MODE_STRAP  = 3'b001,
		MODE_EEPROM = 3'b010,
		MODE_MIXED  = 3'b100
	} cil_mode_e;
endpackage : cil_pkg

// File: rtl/cil_eeprom_reader.sv
`timescale 1ns/10ps
module cil_eeprom_reader
	import cil_pkg::*;
(
	input  wire logic                 clk_sys,
	input  wire logic                 rst_n,
	input  wire logic                 start,
	input  wire logic [ADDR_BITS-1:0] addr,
	input  wire logic                 data_in,
	output logic                      busy,
	output logic                      done,
	output logic [15:0]               word,
	output logic                      chip_sel,
	output logic                      ser_clk,
	output logic                      ser_out
);
	logic [7:0]           cnt_q;
	logic [4:0]           bit_q;
	logic [8:0]           shift_q;
	logic                 gap_q;

	// one word read: select, command out, data in on rising edges
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			busy     <= 1'b0;
			done     <= 1'b0;
			word     <= 16'h0000;
			chip_sel <= 1'b0;
			ser_clk  <= 1'b0;
			ser_out  <= 1'b0;
			cnt_q    <= 8'h00;
			bit_q    <= 5'h00;
			shift_q  <= 9'h000;
			gap_q    <= 1'b0;
		end else begin
			done <= 1'b0;
			if (!busy) begin
				if (start) begin
					busy     <= 1'b1;
					chip_sel <= 1'b1;
					shift_q  <= {READ_CMD, addr};
					ser_out  <= READ_CMD[2];
					cnt_q    <= 8'h00;
					bit_q    <= 5'h00;
				end
			end else if (cnt_q != SK_HALF_CLKS - 8'h01) begin
				cnt_q <= cnt_q + 8'h01;
			end else begin
				cnt_q <= 8'h00;
				if (gap_q) begin
					// select stays low a half period between words
					gap_q <= 1'b0;
					busy  <= 1'b0;
					done  <= 1'b1;
				end else if (!ser_clk) begin
					ser_clk <= 1'b1;
					if (bit_q >= OUT_BITS)
						word <= {word[14:0], data_in};
				end else begin
					ser_clk <= 1'b0;
					if (bit_q == LAST_BIT) begin
						chip_sel <= 1'b0;
						gap_q    <= 1'b1;
					end else begin
						bit_q   <= bit_q + 5'h01;
						shift_q <= {shift_q[7:0], 1'b0};
						ser_out <= (bit_q + 5'h01 < OUT_BITS) & shift_q[7];
					end
				end
			end
		end
	end
endmodule : cil_eeprom_reader

// File: rtl/cil_bus_mode_timer.sv
`timescale 1ns/10ps
module cil_bus_mode_timer
	import cil_pkg::*;
#(
	parameter int unsigned BASE_UNIT_CLKS = BASE_UNIT_PERIODS
) (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       auto_run,
	input  wire logic       msg_received,
	output logic [1:0]      bus_mode
);
	logic [15:0] unit_q;
	logic [3:0]  silent_q;

	// base time unit and silence count
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			unit_q   <= 16'h0000;
			silent_q <= 4'h0;
			bus_mode <= 2'h0;
		end else if (!auto_run || msg_received) begin
			unit_q   <= 16'h0000;
			silent_q <= 4'h0;
		end else if (unit_q != 16'(BASE_UNIT_CLKS - 1)) begin
			unit_q <= unit_q + 16'h0001;
		end else begin
			unit_q <= 16'h0000;
			if (silent_q == 4'(SILENT_UNITS - 1)) begin
				// mode 3 is not allowed, so wrap after mode 2
				silent_q <= 4'h0;
				bus_mode <= (bus_mode == BUS_MODE_LAST) ? 2'h0
					: bus_mode + 2'h1;
			end else begin
				silent_q <= silent_q + 4'h1;
			end
		end
	end
endmodule : cil_bus_mode_timer

// File: rtl/cil_config_loader.sv
`timescale 1ns/10ps
module cil_config_loader
	import cil_pkg::*;
#(
	parameter int unsigned BASE_UNIT_CLKS = BASE_UNIT_PERIODS
) (
	input  wire logic        clk_sys,
	input  wire logic        arst_n,
	input  wire logic [3:0]  ident_pin_in,
	output logic [3:0]       ident_pin_out,
	output logic [3:0]       ident_pin_oe_n,
	input  wire logic        msg_received,
	input  wire logic        error_passive_flag,
	input  wire logic [7:0]  port_low_status,
	input  wire logic        status_tx_done,
	output logic             status_tx_req,
	output logic [7:0]       status_byte_marker,
	output logic [7:0]       status_byte_data,
	output logic             can_enable,
	output logic             init_busy,
	output logic             eeprom_config_mode,
	output logic             mixed_strap_eeprom_mode,
	output logic [10:0]      node_tx_ident,
	output logic [10:0]      node_rx_ident,
	output logic [10:0]      global_rx_ident,
	output logic             global_ident_valid,
	output logic [7:0]       bit_rate_prescaler,
	output logic [6:0]       sample_point_pct,
	output logic [2:0]       sync_jump_quanta,
	output logic [1:0]       bus_mode_field,
	output logic             bus_mode_auto,
	output logic [7:0]       rise_edge_enable,
	output logic [7:0]       fall_edge_enable,
	output logic [7:0]       low_port_output,
	output logic [7:0]       high_port_output,
	output logic [7:0]       low_port_direction,
	output logic [7:0]       high_port_direction,
	output logic [7:0]       analog_out_low,
	output logic [7:0]       analog_out_high,
	output logic [7:0]       analog_out_control,
	output logic [7:0]       comparator_control,
	output logic [7:0]       node_config_reg
);
	typedef enum logic [6:0] {
		S_SETTLE = 7'b0000001,
		S_STRAP  = 7'b0000010,
		S_CSHOLD = 7'b0000100,
		S_WAIT   = 7'b0001000,
		S_LATCH  = 7'b0010000,
		S_STATUS = 7'b0100000,
		S_RUN    = 7'b1000000
	} cil_state_e;

	cil_state_e  state_q;
	cil_mode_e   mode_q;
	logic        rst_s1_q;
	logic        rst_n_q;
	logic [3:0]  pin_s1_q;
	logic [3:0]  pin_s2_q;
	logic [3:0]  pin_s3_q;
	logic [3:0]  pin_filt_q;
	logic [3:0]  strap_q;
	logic [3:0]  settle_q;
	logic [3:0]  word_idx_q;
	logic [15:0] words_q [1:8];
	logic        rd_start;
	logic        rd_busy;
	logic        rd_done;
	logic [15:0] rd_word;
	logic        rd_cs;
	logic        rd_sk;
	logic        rd_di;
	logic [1:0]  timer_mode;
	logic [9:0]  ident_mem;
	logic [9:0]  ident_sel;

	function automatic logic [9:0] build_ident(input logic [15:0] w);
		// high byte holds bits 9-7, low byte 6-0 above the direction bit
		return {w[10:8], w[7:1]};
	endfunction : build_ident

	function automatic logic is_fast(input logic [7:0] psc);
		return ({1'b0, psc} + 9'h001) <= FAST_PSC_LIMIT;
	endfunction : is_fast

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// pins are asynchronous; a change counts once stages two and three agree
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pin_s1_q   <= 4'h0;
			pin_s2_q   <= 4'h0;
			pin_s3_q   <= 4'h0;
			pin_filt_q <= 4'h0;
		end else begin
			pin_s1_q   <= ident_pin_in;
			pin_s2_q   <= pin_s1_q;
			pin_s3_q   <= pin_s2_q;
			pin_filt_q <= (pin_s2_q & ~(pin_s2_q ^ pin_s3_q))
				| (pin_filt_q & (pin_s2_q ^ pin_s3_q));
		end
	end

	assign rd_start = (state_q == S_CSHOLD);

	cil_eeprom_reader u_reader (
		.clk_sys  (clk_sys),
		.rst_n    (rst_n_q),
		.start    (rd_start),
		.addr     ({2'b00, word_idx_q}),
		.data_in  (pin_filt_q[3]),
		.busy     (rd_busy),
		.done     (rd_done),
		.word     (rd_word),
		.chip_sel (rd_cs),
		.ser_clk  (rd_sk),
		.ser_out  (rd_di)
	);

	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q    <= S_SETTLE;
			mode_q     <= MODE_STRAP;
			settle_q   <= 4'h0;
			strap_q    <= 4'h0;
			word_idx_q <= W_MARKER;
		end else begin
			unique case (state_q)
				S_SETTLE: begin
					settle_q <= settle_q + 4'h1;
					if (settle_q == STRAP_SETTLE_CLKS - 4'h1)
						state_q <= S_STRAP;
				end
				S_STRAP: begin
					// straps caught while every pin is still released
					strap_q <= pin_filt_q;
					state_q <= S_CSHOLD;
				end
				S_CSHOLD: state_q <= S_WAIT;
				S_WAIT: begin
					if (rd_done) begin
						if (word_idx_q == W_MARKER) begin
							if (rd_word[7:0] == MIXED_MODE_MARKER) begin
								mode_q     <= MODE_MIXED;
								word_idx_q <= W_IDENT;
								state_q    <= S_CSHOLD;
							end else if (rd_word[15:8]
								== EEPROM_VALID_MARKER) begin
								mode_q     <= MODE_EEPROM;
								word_idx_q <= W_IDENT;
								state_q    <= S_CSHOLD;
							end else begin
								mode_q  <= MODE_STRAP;
								state_q <= S_LATCH;
							end
						end else if (word_idx_q == W_CONFIG) begin
							state_q <= S_LATCH;
						end else begin
							word_idx_q <= word_idx_q + 4'h1;
							state_q    <= S_CSHOLD;
						end
					end
				end
				S_LATCH: state_q <= S_STATUS;
				S_STATUS: if (status_tx_done) state_q <= S_RUN;
				S_RUN: state_q <= S_RUN;
				default: state_q <= S_SETTLE;
			endcase
		end
	end

	// each word after the marker kept separately under its own address
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			for (int i = 1; i <= 8; i++)
				words_q[i] <= 16'h0000;
		end else if (state_q == S_WAIT && rd_done
			&& word_idx_q != W_MARKER) begin
			words_q[word_idx_q] <= rd_word;
		end
	end

	// pin drive is registered so the port never glitches on a state change
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ident_pin_out  <= 4'h0;
			ident_pin_oe_n <= 4'hF;
		end else if (state_q == S_CSHOLD || state_q == S_WAIT) begin
			// select low outside a read, serial lines shared
			ident_pin_out  <= {1'b0, rd_di, rd_sk, rd_cs};
			ident_pin_oe_n <= 4'h8;
		end else begin
			ident_pin_out  <= 4'h0;
			ident_pin_oe_n <= 4'hF;
		end
	end

	assign ident_mem = build_ident(words_q[W_IDENT]);
	always_comb begin
		unique case (mode_q)
			MODE_EEPROM: ident_sel = ident_mem;
			MODE_MIXED:  ident_sel = {ident_mem[9:4], strap_q[3:1],
				1'b0};
			default:     ident_sel = {STRAP_IDENT_HIGH, strap_q};
		endcase
	end

	// everything settles in one edge, well ahead of the enable
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			node_tx_ident       <= 11'h000;
			node_rx_ident       <= 11'h001;
			global_rx_ident     <= 11'h001;
			global_ident_valid  <= 1'b0;
			bit_rate_prescaler  <= STRAP_PRESCALER;
			eeprom_config_mode  <= 1'b0;
			mixed_strap_eeprom_mode <= 1'b0;
		end else if (state_q == S_LATCH) begin
			node_tx_ident   <= {ident_sel, 1'b0};
			node_rx_ident   <= {ident_sel, 1'b1};
			global_rx_ident <= {build_ident(words_q[W_GLOBAL]),
				1'b1};
			global_ident_valid <= (mode_q != MODE_STRAP);
			eeprom_config_mode <= (mode_q == MODE_EEPROM);
			mixed_strap_eeprom_mode <= (mode_q == MODE_MIXED);
			if (mode_q == MODE_STRAP)
				bit_rate_prescaler <= STRAP_PRESCALER;
			else
				bit_rate_prescaler <= words_q[W_CONFIG][7:0];
		end
	end

	// register block; the strap defaults are also the reset values
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rise_edge_enable    <= REG_DEFAULT;
			fall_edge_enable    <= REG_DEFAULT;
			low_port_output     <= OUTPUT_DEFAULT;
			high_port_output    <= OUTPUT_DEFAULT;
			low_port_direction  <= REG_DEFAULT;
			high_port_direction <= REG_DEFAULT;
			analog_out_high     <= REG_DEFAULT;
			analog_out_low      <= REG_DEFAULT;
			analog_out_control  <= REG_DEFAULT;
			comparator_control  <= REG_DEFAULT;
			node_config_reg     <= REG_DEFAULT;
		end else if (state_q == S_LATCH) begin
			if (mode_q == MODE_STRAP) begin
				rise_edge_enable    <= REG_DEFAULT;
				fall_edge_enable    <= REG_DEFAULT;
				low_port_output     <= OUTPUT_DEFAULT;
				high_port_output    <= OUTPUT_DEFAULT;
				low_port_direction  <= REG_DEFAULT;
				high_port_direction <= REG_DEFAULT;
				analog_out_high     <= REG_DEFAULT;
				analog_out_low      <= REG_DEFAULT;
				analog_out_control  <= REG_DEFAULT;
				comparator_control  <= REG_DEFAULT;
				node_config_reg     <= REG_DEFAULT;
			end else begin
				rise_edge_enable    <= words_q[W_EDGE][15:8];
				fall_edge_enable    <= words_q[W_EDGE][7:0];
				low_port_output     <= words_q[W_OUTPUT][15:8];
				high_port_output    <= words_q[W_OUTPUT][7:0];
				low_port_direction  <= words_q[W_DIR][15:8];
				high_port_direction <= words_q[W_DIR][7:0];
				analog_out_high     <= words_q[W_ANALOG][15:8];
				analog_out_low      <= words_q[W_ANALOG][7:0];
				analog_out_control  <= words_q[W_CTRL][15:8];
				comparator_control  <= words_q[W_CTRL][7:0];
				node_config_reg     <= words_q[W_CONFIG][15:8];
			end
		end
	end

	// bit timing follows the selected rate
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sample_point_pct <= SAMPLE_PCT_SLOW;
			sync_jump_quanta <= SJW_SLOW;
		end else if (is_fast(bit_rate_prescaler)) begin
			sample_point_pct <= SAMPLE_PCT_FAST;
			sync_jump_quanta <= SJW_FAST;
		end else begin
			sample_point_pct <= SAMPLE_PCT_SLOW;
			sync_jump_quanta <= SJW_SLOW;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q)
			bus_mode_auto <= 1'b0;
		else if (state_q == S_LATCH)
			bus_mode_auto <= (mode_q == MODE_STRAP);
	end

	cil_bus_mode_timer #(
		.BASE_UNIT_CLKS (BASE_UNIT_CLKS)
	) u_timer (
		.clk_sys      (clk_sys),
		.rst_n        (rst_n_q),
		.auto_run     (bus_mode_auto && can_enable),
		.msg_received (msg_received),
		.bus_mode     (timer_mode)
	);

	// fixed modes stay on dual wire; run-time mode writes are elsewhere
	assign bus_mode_field = bus_mode_auto ? timer_mode : 2'h0;

	// status frame bytes frozen for the whole request
	always_ff @(posedge clk_sys or negedge rst_n_q) begin
		if (!rst_n_q) begin
			status_byte_marker <= 8'h00;
			status_byte_data   <= 8'h00;
		end else if (state_q == S_LATCH) begin
			status_byte_marker <= {error_passive_flag, bus_mode_field,
				MARKER_PORT_LOW};
			status_byte_data   <= port_low_status;
		end
	end

	assign status_tx_req = (state_q == S_STATUS);
	assign can_enable    = (state_q == S_RUN);
	assign init_busy     = (state_q != S_RUN) || rd_busy;
endmodule : cil_config_loader

// File: testbench/cil_config_loader_properties.sv
`timescale 1ns/10ps
module cil_config_loader_checker
	import cil_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        arst_n,
	input wire logic [3:0]  ident_pin_out,
	input wire logic [3:0]  ident_pin_oe_n,
	input wire logic        error_passive_flag,
	input wire logic        status_tx_done,
	input wire logic        status_tx_req,
	input wire logic [7:0]  status_byte_marker,
	input wire logic        can_enable,
	input wire logic        mixed_strap_eeprom_mode,
	input wire logic        eeprom_config_mode,
	input wire logic [10:0] node_tx_ident,
	input wire logic [10:0] node_rx_ident,
	input wire logic [10:0] global_rx_ident,
	input wire logic        global_ident_valid,
	input wire logic [7:0]  bit_rate_prescaler,
	input wire logic [6:0]  sample_point_pct,
	input wire logic [2:0]  sync_jump_quanta,
	input wire logic [1:0]  bus_mode_field
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!arst_n);

	sequence s_done_seen;
		status_tx_req && status_tx_done;
	endsequence
	sequence s_run;
		!status_tx_req && can_enable;
	endsequence

	property p_data_in_free;
		ident_pin_oe_n[3];
	endproperty
	property p_pair;
		!node_tx_ident[0] && node_rx_ident == {node_tx_ident[10:1], 1'b1};
	endproperty
	property p_global_dir;
		global_ident_valid |-> global_rx_ident[0];
	endproperty
	property p_strap_fixed;
		can_enable && !eeprom_config_mode && !mixed_strap_eeprom_mode |->
			node_tx_ident[10:5] == 6'h20 && bit_rate_prescaler == 8'h03;
	endproperty
	property p_mixed_bit0;
		can_enable && mixed_strap_eeprom_mode |-> !node_tx_ident[1];
	endproperty
	property p_timing;
		can_enable |-> (bit_rate_prescaler <= 8'h01) ?
			(sample_point_pct == 7'h50 && sync_jump_quanta == 3'h2) :
			(sample_point_pct == 7'h3C && sync_jump_quanta == 3'h4);
	endproperty
	property p_enable_after_status;
		s_done_seen |=> s_run;
	endproperty
	property p_no_early_enable;
		$rose(can_enable) |-> $past(status_tx_req);
	endproperty
	// settings must not move once the controller runs
	property p_frozen;
		can_enable && $past(can_enable) |-> $stable(node_tx_ident)
			&& $stable(bit_rate_prescaler) && $stable(global_rx_ident);
	endproperty
	property p_cs_low_first;
		$fell(ident_pin_oe_n[0]) |-> !ident_pin_out[0];
	endproperty
	property p_marker;
		$rose(status_tx_req) |-> status_byte_marker ==
			{$past(error_passive_flag), $past(bus_mode_field), 5'h00};
	endproperty

	a_data_in_free:
		assert property (p_data_in_free) else $error("data-in pin driven");
	a_pair:
		assert property (p_pair) else $error("tx/rx identifier pair wrong");
	a_global_dir:
		assert property (p_global_dir) else $error("global dir bit low");
	a_strap_fixed:
		assert property (p_strap_fixed) else $error("strap values wrong");
	a_mixed_bit0:
		assert property (p_mixed_bit0) else $error("mixed ident bit 0 set");
	a_timing:
		assert property (p_timing) else $error("bit timing wrong");
	a_enable_after_status:
		assert property (p_enable_after_status) else $error("no enable");
	a_no_early_enable:
		assert property (p_no_early_enable) else $error("enable early");
	a_frozen:
		assert property (p_frozen) else $error("settings moved");
	a_cs_low_first:
		assert property (p_cs_low_first) else $error("select high early");
	a_marker:
		assert property (p_marker) else $error("status marker wrong");
endmodule : cil_config_loader_checker

bind cil_config_loader cil_config_loader_checker u_chk (
	.clk_sys, .arst_n, .ident_pin_out, .ident_pin_oe_n,
	.error_passive_flag, .status_tx_done, .status_tx_req,
	.status_byte_marker, .can_enable, .mixed_strap_eeprom_mode,
	.eeprom_config_mode, .node_tx_ident, .node_rx_ident, .global_rx_ident,
	.global_ident_valid, .bit_rate_prescaler, .sample_point_pct,
	.sync_jump_quanta, .bus_mode_field
);

// File: testbench/cil_eeprom_model.sv
`timescale 1ns/10ps
module cil_eeprom_model (
	input  wire logic             present,
	input  wire logic             cs,
	input  wire logic             sk,
	input  wire logic             di,
	input  wire logic [8:0][15:0] words,
	output logic                  dout,
	output logic                  drive,
	output logic [2:0]            cmd,
	output logic [5:0]            addr,
	output logic [7:0]            reads
);
	int         n = 0;
	logic [8:0] sh = 9'h000;
	initial begin
		dout = 1'b1;
		drive = 1'b0;
		cmd = 3'h0;
		addr = 6'h00;
		reads = 8'h00;
	end
	// deselected part floats, the strap resistor then sets the line
	always @(negedge cs) begin
		n = 0;
		drive = 1'b0;
	end
	// output lags the clock edge like a real part
	always @(posedge sk) begin
		if (cs && present) begin
			n = n + 1;
			sh = {sh[7:0], di};
			if (n == 9) begin
				cmd = sh[8:6];
				addr = sh[5:0];
				reads = reads + 8'h01;
				drive = 1'b1;
				dout <= #200 1'b0;
			end else if (n >= 10 && n <= 25) begin
				dout <= #200 (addr < 6'h09) ? words[addr][25-n] : 1'b1;
			end
		end
	end
endmodule : cil_eeprom_model

// File: testbench/test_cil_config_loader.sv
`timescale 1ns/10ps
module test_cil_config_loader
	import cil_pkg::*;
;
	localparam int unsigned UNIT = 16;
	logic clk_sys = 0, arst_n = 0, msg_received = 0, status_tx_done = 0;
	logic error_passive_flag = 0, present = 0;
	logic [7:0] port_low_status = 8'h00, base;
	logic [3:0] strap = 4'h0;
	logic [8:0][15:0] words = '0;
	wire [3:0] ident_pin_in;
	logic [3:0] ident_pin_out, ident_pin_oe_n;
	wire mem_dout, mem_drive;
	wire [2:0] mem_cmd;
	wire [5:0] mem_addr;
	wire [7:0] mem_reads;
	logic status_tx_req, can_enable, eeprom_config_mode, global_ident_valid;
	logic mixed_strap_eeprom_mode, bus_mode_auto, init_busy;
	logic [10:0] node_tx_ident, node_rx_ident, global_rx_ident;
	logic [7:0] status_byte_marker, status_byte_data, bit_rate_prescaler;
	logic [6:0] sample_point_pct;
	logic [2:0] sync_jump_quanta;
	logic [1:0] bus_mode_field;
	logic [7:0] rise_edge_enable, fall_edge_enable, low_port_output;
	logic [7:0] high_port_output, low_port_direction, high_port_direction;
	logic [7:0] analog_out_low, analog_out_high, analog_out_control;
	logic [7:0] comparator_control, node_config_reg;
	int fail_count = 0, checks = 0, n;

	// released pins fall back to their strap resistors
	assign ident_pin_in[2:0] = (~ident_pin_oe_n[2:0] & ident_pin_out[2:0])
		| (ident_pin_oe_n[2:0] & strap[2:0]);
	assign ident_pin_in[3] = mem_drive ? mem_dout : strap[3];

	cil_config_loader #(.BASE_UNIT_CLKS(UNIT)) uut (.*);
	cil_eeprom_model u_mem (.present, .cs(ident_pin_in[0]),
		.sk(ident_pin_in[1]), .di(ident_pin_in[2]), .words, .dout(mem_dout),
		.drive(mem_drive), .cmd(mem_cmd), .addr(mem_addr), .reads(mem_reads));

	always #25 clk_sys = ~clk_sys;

	task chk(input string nm, input logic [87:0] got, input logic [87:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task wrap_up;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : wrap_up

	task boot(input logic pres, input logic [3:0] st);
		@(negedge clk_sys);
		arst_n = 0;
		present = pres;
		strap = st;
		base = mem_reads;
		repeat (12) @(negedge clk_sys);
		arst_n = 1;
		n = 0;
		while (status_tx_req !== 1'b1 && n < 30000) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 30000) begin
			chk("init_wait", 0, 1);
			wrap_up();
		end
		// bit timing trails the prescaler by one edge after the latch
		@(negedge clk_sys);
	endtask : boot

	task finish_status(input logic [7:0] mk);
		chk("marker", status_byte_marker, mk);
		chk("data", status_byte_data, port_low_status);
		chk("early", {can_enable, init_busy}, 2'b01);
		status_tx_done = 1;
		@(negedge clk_sys);
		status_tx_done = 0;
		chk("run", {can_enable, status_tx_req, init_busy},
			3'b100);
	endtask : finish_status

	task wait_bm(input logic [1:0] m);
		n = 0;
		while (bus_mode_field !== m && n < 9 * UNIT) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 9 * UNIT) begin
			chk("mode_wait", 0, 1);
			wrap_up();
		end
	endtask : wait_bm

	task common(input logic [10:0] tx, input logic [7:0] psc,
		input logic [9:0] tm, input logic [3:0] md, input logic [87:0] rg);
		chk("tx", node_tx_ident, tx);
		chk("rx", node_rx_ident, {tx[10:1], 1'b1});
		chk("psc", bit_rate_prescaler, psc);
		chk("timing", {sample_point_pct, sync_jump_quanta}, tm);
		chk("mode", {eeprom_config_mode, mixed_strap_eeprom_mode,
			bus_mode_auto, global_ident_valid}, md);
		chk("regs", {rise_edge_enable, fall_edge_enable, low_port_output,
			high_port_output, low_port_direction, high_port_direction,
			analog_out_low, analog_out_high, analog_out_control,
			comparator_control, node_config_reg}, rg);
	endtask : common

	initial begin
		error_passive_flag = 1;
		port_low_status = 8'hC3;
		boot(0, 4'hA);
		common(11'h414, 8'h03, {7'h3C, 3'h4}, 4'b0010,
			88'h0000FFFF00000000000000);
		finish_status(8'h80);
		repeat (4 * UNIT) @(negedge clk_sys);
		// a frame in mid-count must restart the silence count
		for (int m = 1; m < 4; m++) begin
			msg_received = 1;
			@(negedge clk_sys);
			msg_received = 0;
			wait_bm(2'(m % 3));
			chk("silence", n >= 8 * UNIT - 3 && n <= 8 * UNIT + 3, 1);
		end
		$display("strap test done");

		error_passive_flag = 0;
		port_low_status = 8'h5A;
		words = {16'h0801, 16'h03E0, 16'h01B0, 16'h1234, 16'h0100,
			16'hF00B, 16'h0700, 16'h070B, 16'hAA00};
		boot(1, 4'h6);
		common(11'h70A, 8'h01, {7'h50, 3'h2}, 4'b1001,
			88'hF00B01001234B00103E008);
		chk("global", global_rx_ident, 11'h701);
		chk("frame", {mem_reads - base, mem_cmd, mem_addr},
			{8'h09, 3'h6, 6'h08});
		finish_status(8'h00);
		$display("memory test done");

		words[0] = 16'hAA55;
		words[1] = 16'h041E;
		words[8] = 16'h0807;
		boot(1, 4'hC);
		common(11'h418, 8'h07, {7'h3C, 3'h4}, 4'b0101,
			88'hF00B01001234B00103E008);
		finish_status(8'h00);
		$display("mixed test done");

		words[0] = 16'h1234;
		boot(1, 4'h2);
		common(11'h404, 8'h03, {7'h3C, 3'h4}, 4'b0010,
			88'h0000FFFF00000000000000);
		chk("reads", mem_reads - base, 8'h01);
		finish_status(8'h00);
		$display("fallback test done");
		wrap_up();
	end
endmodule : test_cil_config_loader
